// file: rtl/pscg_pkg.sv
// shared constants, state enum and carrier structs for the power-state clock generator
package pscg_pkg;

    // base rates
    localparam int CLK_HZ          = 100_000_000;
    localparam int XTAL_HZ         = 32_768;
    localparam int PLL_MULT        = 112;
    // sys clocks per crystal tick and per high-frequency tick
    localparam int XTAL_DIV_CYCLES = CLK_HZ / XTAL_HZ;
    localparam int HF_DIV_CYCLES   = CLK_HZ / (XTAL_HZ * PLL_MULT);

    // phase generator divide ratios and phase positions
    localparam logic [2:0] AWAKE_DIV  = 3'h6;
    localparam logic [2:0] READ_DIV   = 3'h7;
    localparam logic [2:0] LIGHT_DIV  = 3'h7;
    localparam logic [2:0] PH1_END    = 3'h2;
    localparam logic [2:0] PH2_START  = 3'h3;
    localparam logic [2:0] POS_RST    = 3'h0;

    // supply settle and reset-key hold times
    localparam int SETTLE_MS       = 56;
    localparam int SETTLE_CYCLES   = SETTLE_MS * (CLK_HZ / 1000);
    localparam int KEY_HOLD_S      = 5;
    localparam int KEY_HOLD_CYCLES = KEY_HOLD_S * CLK_HZ;

    // reset values
    localparam logic        SLEEP_CTL_RST = 1'b1;
    localparam logic        BUZZ_N_RST    = 1'b1;
    localparam logic [31:0] CNT_RST       = 32'h0000_0000;
    localparam logic [15:0] DIV_CNT_RST   = 16'h0000;

    typedef enum logic [1:0] {
        PSCG_DEEP,
        PSCG_LIGHT,
        PSCG_AWAKE
    } pscg_state_t;

    // commands and requests from cpu decode and keyboard logic
    typedef struct packed {
        logic go_deep;
        logic go_light;
        logic wake_key;
        logic wake_cmp;
        logic dev_read;
        logic flag_clear;
        logic gie_set;
        logic gie_clear;
        logic reset_keys;
        logic buzz_n;
    } pscg_ctl_t;

    // state seen by the rest of the chip
    typedef struct packed {
        pscg_state_t state;
        logic        power_up_flag;
        logic        gie;
        logic        pll_on;
        logic        powered;
    } pscg_stat_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } pscg_div_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic out;
    } pscg_sync_t;

    typedef struct packed {
        pscg_state_t state;
        logic        flag;
        logic        gie;
        logic        pll_on;
        logic        buzz_n;
        logic        sleep_ctl;
        logic        pwo_oe_n;
        logic        powered;
        logic [31:0] settle_cnt;
        logic [31:0] key_cnt;
        logic [2:0]  pos;
        logic [2:0]  div;
        logic        src_hf;
        logic        run;
        logic        ph1;
        logic        ph2;
    } pscg_core_t;

endpackage

// file: rtl/pscg_tick_div.sv
// enable-pulse divider: one-cycle tick every PERIOD system clocks while enabled
`timescale 1ns/1ps
module pscg_tick_div
    import pscg_pkg::*;
#(
    parameter int PERIOD = 27
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic en,
    output logic      tick
);

    pscg_div_t q_r;
    pscg_div_t q_nxt;

    // count up the period, restart when disabled
    always_comb begin
        q_nxt      = q_r;
        q_nxt.tick = 1'b0;
        if (!en) begin
            q_nxt.cnt = DIV_CNT_RST;
        end else if (q_r.cnt == 16'(PERIOD - 1)) begin
            q_nxt.cnt  = DIV_CNT_RST;
            q_nxt.tick = 1'b1;
        end else begin
            q_nxt.cnt = q_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q_r <= '{cnt: DIV_CNT_RST, tick: 1'b0};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign tick = q_r.tick;

endmodule

// file: rtl/pscg_sync3.sv
// three-flop pin synchroniser; output moves only when flops two and three agree
`timescale 1ns/1ps
module pscg_sync3
    import pscg_pkg::*;
#(
    parameter logic INIT = 1'b0
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic din,
    output logic      dout
);

    pscg_sync_t q_r;
    pscg_sync_t q_nxt;

    // shift chain; first flop feeds only the second
    always_comb begin
        q_nxt    = q_r;
        q_nxt.s1 = din;
        q_nxt.s2 = q_r.s1;
        q_nxt.s3 = q_r.s2;
        if (q_r.s2 == q_r.s3) begin
            q_nxt.out = q_r.s3;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q_r <= '{s1: INIT, s2: INIT, s3: INIT, out: INIT};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign dout = q_r.out;

endmodule

// file: rtl/pscg_top.sv
// power-state sequencer and two-phase system clock generator
//
// What this block does
// R1 - three states only: deep sleep, light sleep, awake; outputs follow the state
// R2 - two-phase clock; control strobes valid in phase two, data in phase one
// R3 - awake phases run near 611 kHz
// R4 - light sleep phases run near 4.68 kHz
// R5 - full-reset deep sleep holds both phase outputs low; a commanded deep sleep freezes them at their last level
// R6 - pll multiplies 32.768 kHz crystal by 112 to about 3.67 MHz
// R7 - awake divides the pll clock by 6 unless this device is read
// R8 - light sleep divides the crystal clock by 7; pll on but unused
// R9 - a read of this device stretches the pll divide to 7
// R10 - supply fail or power-ok low outside deep sleep gives full reset
// R11 - reset-key combination held five seconds forces the full reset
// R12 - initial deep sleep: flag clear, power-ok low, sleep-control high, pll off
// R13 - initial deep sleep: interrupts disabled, buzzer output high
// R14 - cpu commands normal deep sleep: flag set, comparator may wake
// R15 - cpu commands light sleep: flag set, power-ok high, sleep-control low
// R16 - keyboard entry or comparator interrupt moves to awake
// R17 - awake keeps the flag; software clears it before leaving
// R18 - awake: power-ok high, sleep-control low, pll feeds the generator
// R19 - power-ok low resets only once 56 ms passed since sleep-control fell
// R20 - buzzer output active low, tone is a square wave on it
// R21 - sleep-control high asks deep-sleep supply, low asks awake supply
// R22 - allow 56 ms supply settle after sleep-control falls
// R23 - phases never overlap; divide changes only at cycle boundaries
`timescale 1ns/1ps
module pscg_top
    import pscg_pkg::*;
#(
    parameter int SETTLE_CYC   = SETTLE_CYCLES,
    parameter int KEY_HOLD_CYC = KEY_HOLD_CYCLES
) (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire pscg_ctl_t  ctl,
    input  wire logic       supply_fail,
    input  wire logic       power_ok_reset_n_i,
    output logic            power_ok_reset_n_o,
    output logic            power_ok_reset_n_oe_n,
    output logic            phase_one_clock,
    output logic            phase_two_clock,
    output logic            sleep_ctl,
    output logic            buzzer_n,
    output pscg_stat_t      stat
);

    pscg_core_t  q_r;
    pscg_core_t  q_nxt;
    logic        xtal_tick;
    logic        hf_tick;
    logic        fail_s;
    logic        pwo_s;
    logic        gen_tick;
    logic        key_fire;
    logic        pwo_fire;
    logic        full_reset;
    pscg_state_t st_nxt;

    // crystal time base, always running
    pscg_tick_div #(
        .PERIOD (XTAL_DIV_CYCLES)
    ) u_xtal (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .en      (1'b1),
        .tick    (xtal_tick)
    );

    // pll high-frequency time base, gated by pll enable
    pscg_tick_div #(
        .PERIOD (HF_DIV_CYCLES)
    ) u_pll (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .en      (q_r.pll_on), // R6
        .tick    (hf_tick)
    );

    // supply fail detector pin
    pscg_sync3 #(
        .INIT (1'b0)
    ) u_fail_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .din     (supply_fail),
        .dout    (fail_s)
    );

    // power-ok wire level, may be pulled low by the supply comparator
    pscg_sync3 #(
        .INIT (1'b1)
    ) u_pwo_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .din     (power_ok_reset_n_i),
        .dout    (pwo_s)
    );

    // reset causes
    assign key_fire   = ctl.reset_keys && (q_r.key_cnt == 32'(KEY_HOLD_CYC - 1)); // R11
    assign pwo_fire   = !pwo_s && q_r.powered && (q_r.state != PSCG_DEEP); // R10 R19
    assign full_reset = fail_s || key_fire || pwo_fire; // R10
    assign gen_tick   = q_r.src_hf ? hf_tick : xtal_tick;

    always_comb begin
        q_nxt  = q_r;
        st_nxt = q_r.state;

        // five-second reset-key hold counter
        if (!ctl.reset_keys || key_fire) begin
            q_nxt.key_cnt = CNT_RST;
        end else begin
            q_nxt.key_cnt = q_r.key_cnt + 32'h0000_0001; // R11
        end

        // state sequencing
        case (q_r.state)
            PSCG_DEEP: begin
                if (ctl.wake_key || (ctl.wake_cmp && q_r.flag)) begin
                    st_nxt = PSCG_AWAKE; // R14 R16
                end
            end
            PSCG_LIGHT: begin
                if (ctl.wake_key || ctl.wake_cmp) begin
                    st_nxt = PSCG_AWAKE; // R16
                end
            end
            PSCG_AWAKE: begin
                if (ctl.go_deep) begin
                    st_nxt = PSCG_DEEP; // R14
                end else if (ctl.go_light) begin
                    st_nxt = PSCG_LIGHT; // R15
                end
            end
            default: begin
                st_nxt = PSCG_DEEP;
            end
        endcase

        // power-up flag: set by sleep commands, set wins over clear
        if (q_r.state == PSCG_AWAKE && (ctl.go_deep || ctl.go_light)) begin
            q_nxt.flag = 1'b1; // R14 R15
        end else if (q_r.state == PSCG_AWAKE && ctl.flag_clear) begin
            q_nxt.flag = 1'b0; // R17
        end

        // global interrupt enable, software driven outside initial deep sleep
        if (ctl.gie_set) begin
            q_nxt.gie = 1'b1;
        end else if (ctl.gie_clear) begin
            q_nxt.gie = 1'b0;
        end

        // full reset returns to initial deep sleep
        if (full_reset) begin
            st_nxt     = PSCG_DEEP; // R10 R12
            q_nxt.flag = 1'b0;
        end
        if (st_nxt == PSCG_DEEP && !q_nxt.flag) begin
            q_nxt.gie = 1'b0; // R13
        end
        q_nxt.state = st_nxt; // R1

        // state-driven outputs
        q_nxt.sleep_ctl = (st_nxt == PSCG_DEEP); // R21 R12 R18
        q_nxt.pwo_oe_n  = (st_nxt != PSCG_DEEP); // R12 R15 R18
        q_nxt.pll_on    = (st_nxt != PSCG_DEEP); // R6 R8 R12
        q_nxt.buzz_n    = (st_nxt == PSCG_DEEP) ? 1'b1 : ctl.buzz_n; // R13 R20

        // supply settle window after sleep-control falls
        if (q_nxt.sleep_ctl) begin
            q_nxt.settle_cnt = CNT_RST;
            q_nxt.powered    = 1'b0;
        end else if (q_r.settle_cnt != 32'(SETTLE_CYC - 1)) begin
            q_nxt.settle_cnt = q_r.settle_cnt + 32'h0000_0001; // R22
        end else begin
            q_nxt.powered = 1'b1; // R19 R22
        end

        // phase generator; divisor and source reload only at cycle end or while stopped
        // a stopped generator starts only on a tick of its new source, so phase one is never cut short
        if (!q_r.run) begin
            q_nxt.pos    = POS_RST;
            q_nxt.run    = (st_nxt != PSCG_DEEP) && ((st_nxt == PSCG_AWAKE) ? hf_tick : xtal_tick); // R5 R23
            q_nxt.src_hf = (st_nxt == PSCG_AWAKE);
            q_nxt.div    = (st_nxt == PSCG_AWAKE) ? (ctl.dev_read ? READ_DIV : AWAKE_DIV) : LIGHT_DIV;
        end else if (gen_tick) begin
            if (q_r.pos == q_r.div - 3'h1) begin
                q_nxt.pos    = POS_RST; // R23
                // a source change stops the generator; it restarts aligned to the new source
                q_nxt.run    = (st_nxt != PSCG_DEEP) && ((st_nxt == PSCG_AWAKE) == q_r.src_hf); // R5 R23
                q_nxt.src_hf = (st_nxt == PSCG_AWAKE); // R7 R8 R18
                if (st_nxt == PSCG_AWAKE) begin
                    q_nxt.div = ctl.dev_read ? READ_DIV : AWAKE_DIV; // R3 R7 R9
                end else begin
                    q_nxt.div = LIGHT_DIV; // R4 R8
                end
            end else begin
                q_nxt.pos = q_r.pos + 3'h1;
            end
        end

        // phase one leads, gap, phase two, gap: never both high
        q_nxt.ph1 = q_nxt.run && (q_nxt.pos < PH1_END); // R2 R23
        q_nxt.ph2 = q_nxt.run && (q_nxt.pos >= PH2_START)
                    && (q_nxt.pos <= q_nxt.div - 3'h2); // R2 R23
        if (full_reset) begin
            q_nxt.run = 1'b0; // R5
            q_nxt.ph1 = 1'b0;
            q_nxt.ph2 = 1'b0;
            q_nxt.pos = POS_RST;
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q_r <= '{state: PSCG_DEEP, flag: 1'b0, gie: 1'b0, pll_on: 1'b0,
                     buzz_n: BUZZ_N_RST, sleep_ctl: SLEEP_CTL_RST, pwo_oe_n: 1'b0,
                     powered: 1'b0, settle_cnt: CNT_RST, key_cnt: CNT_RST,
                     pos: POS_RST, div: LIGHT_DIV, src_hf: 1'b0, run: 1'b0,
                     ph1: 1'b0, ph2: 1'b0};
        end else begin
            q_r <= q_nxt;
        end
    end

    // outputs straight from the state register, except the power-ok level, which is tied low
    assign phase_one_clock       = q_r.ph1;
    assign phase_two_clock       = q_r.ph2;
    assign sleep_ctl             = q_r.sleep_ctl;
    assign buzzer_n              = q_r.buzz_n;
    assign power_ok_reset_n_o    = 1'b0; // only ever drives low
    assign power_ok_reset_n_oe_n = q_r.pwo_oe_n;
    assign stat.state            = q_r.state;
    assign stat.power_up_flag    = q_r.flag;
    assign stat.gie              = q_r.gie;
    assign stat.pll_on           = q_r.pll_on;
    assign stat.powered          = q_r.powered;

endmodule

// file: tb/pscg_props.sv
// port-level assertions for the power-state clock generator
`timescale 1ns/1ps
module pscg_props
    import pscg_pkg::*;
#(
    parameter int SETTLE_CYC   = 20,
    parameter int KEY_HOLD_CYC = 30
) (
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire pscg_ctl_t  ctl,
    input wire logic       supply_fail,
    input wire logic       power_ok_reset_n_i,
    input wire logic       power_ok_reset_n_oe_n,
    input wire logic       phase_one_clock,
    input wire logic       phase_two_clock,
    input wire logic       sleep_ctl,
    input wire logic       buzzer_n,
    input wire pscg_stat_t stat
);
    logic [15:0] hi_r;
    logic [15:0] hi_nxt;
    logic        quiet;
    // length of the current phase-one pulse
    always_comb hi_nxt = phase_one_clock ? hi_r + 16'h0001 : 16'h0000;
    always_ff @(posedge clk_sys) hi_r <= sys_rst ? 16'h0000 : hi_nxt;
    // no supply-fail or reset-key full-reset source pending
    assign quiet = !supply_fail && !ctl.reset_keys;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_no_overlap;
        !(phase_one_clock && phase_two_clock);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("phases overlap");
    property p_first_deep;
        stat.state == PSCG_DEEP && !stat.power_up_flag |-> !phase_one_clock && !phase_two_clock;
    endproperty
    a_first_deep: assert property (p_first_deep) else $error("clock in first deep sleep");
    property p_first_off;
        stat.state == PSCG_DEEP && !stat.power_up_flag |-> !stat.gie && !stat.pll_on;
    endproperty
    a_first_off: assert property (p_first_off) else $error("gie or pll on in first deep sleep");
    property p_deep_pins;
        stat.state == PSCG_DEEP |-> sleep_ctl && !power_ok_reset_n_oe_n && buzzer_n;
    endproperty
    a_deep_pins: assert property (p_deep_pins) else $error("deep sleep pin levels");
    property p_up_pins;
        stat.state != PSCG_DEEP |-> !sleep_ctl && power_ok_reset_n_oe_n && stat.pll_on;
    endproperty
    a_up_pins: assert property (p_up_pins) else $error("powered state pin levels");
    property p_wake;
        stat.state != PSCG_AWAKE && ctl.wake_key && quiet |=> stat.state == PSCG_AWAKE;
    endproperty
    a_wake: assert property (p_wake) else $error("key did not wake");
    property p_go_deep;
        stat.state == PSCG_AWAKE && ctl.go_deep && quiet && power_ok_reset_n_i
            |=> stat.state == PSCG_DEEP && stat.power_up_flag;
    endproperty
    a_go_deep: assert property (p_go_deep) else $error("deep sleep command");
    property p_ph1_width;
        $fell(phase_one_clock) && stat.state != PSCG_DEEP
            |-> hi_r == 2 * HF_DIV_CYCLES || hi_r == 2 * XTAL_DIV_CYCLES;
    endproperty
    a_ph1_width: assert property (p_ph1_width) else $error("phase one width");
endmodule

bind pscg_top pscg_props #(.SETTLE_CYC(SETTLE_CYC), .KEY_HOLD_CYC(KEY_HOLD_CYC)) u_props (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ctl(ctl), .supply_fail(supply_fail),
    .power_ok_reset_n_i(power_ok_reset_n_i), .power_ok_reset_n_oe_n(power_ok_reset_n_oe_n),
    .phase_one_clock(phase_one_clock), .phase_two_clock(phase_two_clock),
    .sleep_ctl(sleep_ctl), .buzzer_n(buzzer_n), .stat(stat));

// file: tb/pscg_cpu_model.sv
// cpu-side model: read strobe timed on phase two, power-ok wire with pull-up
`timescale 1ns/1ps
module pscg_cpu_model
    import pscg_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        read_req,
    input  wire logic        pull_low,
    input  wire logic        phase_two_clock,
    input  wire pscg_state_t state,
    input  wire logic        pok_o,
    input  wire logic        pok_oe_n,
    output logic             dev_read,
    output logic             pok_wire
);
    logic ph2_q;
    // control strobe moves as phase two rises while awake, and is held low outside awake
    always_ff @(posedge clk_sys) begin
        ph2_q <= phase_two_clock;
        if (state != PSCG_AWAKE)
            dev_read <= 1'b0;
        else if (phase_two_clock && !ph2_q)
            dev_read <= read_req;
    end
    // open-drain wire: low if anyone pulls, else the pull-up wins
    assign pok_wire = ((!pok_oe_n && !pok_o) || pull_low) ? 1'b0 : 1'b1;
endmodule

// file: tb/test_power_state_clock_generator.sv
// self-checking bench for the power-state clock generator
`timescale 1ns/1ps
module test_power_state_clock_generator
    import pscg_pkg::*;
;
    localparam pscg_ctl_t IDLE = 10'h001;
    logic       clk_sys, sys_rst, supply_fail, pull_low, read_req, rd, pok_wire;
    logic       pok_o, pok_oe_n, ph1, ph2, sleep_ctl, buzzer_n;
    pscg_ctl_t  ctl_b, ctl_in;
    pscg_stat_t stat;
    int         fail_count, tests_run, seed, per;
    logic [2:0] exp_sf;

    // 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // read strobe comes from the cpu model
    always_comb begin
        ctl_in = ctl_b;
        ctl_in.dev_read = (rd === 1'b1);
    end
    pscg_top #(.SETTLE_CYC(20), .KEY_HOLD_CYC(30)) dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .ctl(ctl_in), .supply_fail(supply_fail),
        .power_ok_reset_n_i(pok_wire), .power_ok_reset_n_o(pok_o), .power_ok_reset_n_oe_n(pok_oe_n),
        .phase_one_clock(ph1), .phase_two_clock(ph2), .sleep_ctl(sleep_ctl), .buzzer_n(buzzer_n),
        .stat(stat));
    pscg_cpu_model cpu (
        .clk_sys(clk_sys), .read_req(read_req), .pull_low(pull_low), .phase_two_clock(ph2),
        .state(stat.state), .pok_o(pok_o), .pok_oe_n(pok_oe_n), .dev_read(rd), .pok_wire(pok_wire));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // hold a control word for n cycles, then idle
    task automatic drive(input pscg_ctl_t c, input int n);
        @(posedge clk_sys);
        ctl_b <= c;
        repeat (n) @(posedge clk_sys);
        ctl_b <= IDLE;
        #1;
    endtask
    // pulse a far-side pin for n cycles: sel 0 pulls power-ok low, sel 1 raises supply fail
    task automatic pin(input logic sel, input int n);
        @(posedge clk_sys);
        if (sel)
            supply_fail <= 1'b1;
        else
            pull_low <= 1'b1;
        repeat (n) @(posedge clk_sys);
        supply_fail <= 1'b0;
        pull_low <= 1'b0;
        cyc(8);
    endtask
    // cycles from one phase-one rise to the next
    task automatic measure(output int p);
        int n;
        for (n = 0; n < 30000 && ph1 !== 1'b0; n++) @(negedge clk_sys);
        for (n = 0; n < 30000 && ph1 !== 1'b1; n++) @(negedge clk_sys);
        for (p = 0; p < 30000 && ph1 !== 1'b0; p++) @(negedge clk_sys);
        for (; p < 30000 && ph1 !== 1'b1; p++) @(negedge clk_sys);
    endtask
    // expected {state, flag} after one edge
    function automatic logic [2:0] nxt(input logic [2:0] sf, input pscg_ctl_t c);
        logic [1:0] s;
        logic       f;
        s = sf[2:1];
        f = sf[0];
        if (s == PSCG_AWAKE) begin
            if (c.go_deep || c.go_light)
                return {c.go_deep ? PSCG_DEEP : PSCG_LIGHT, 1'b1};
            f = f & ~c.flag_clear;
        end else if (c.wake_key || (c.wake_cmp && (f || s == PSCG_LIGHT)))
            s = PSCG_AWAKE;
        return {s, f};
    endfunction
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog
    initial begin
        #900_000;
        fail_count++;
        stop_test();
    end
    // main sequence
    initial begin
        seed = 60;
        fail_count = 0;
        tests_run = 0;
        ctl_b = IDLE;
        sys_rst = 1'b1;
        supply_fail = 1'b0;
        pull_low = 1'b0;
        read_req = 1'b0;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        cyc(1);
        chk(stat, {PSCG_DEEP, 4'h0});
        chk({sleep_ctl, pok_oe_n, buzzer_n, ph1, ph2}, 5'h14);
        drive(10'h041, 1);
        chk(stat.state, PSCG_DEEP);
        done("reset");
        drive(10'h081, 1);
        chk({stat.state, stat.pll_on, sleep_ctl, pok_oe_n}, {PSCG_AWAKE, 3'h5});
        pin(1'b0, 5);
        chk(stat.state, PSCG_AWAKE);
        cyc(30);
        drive(10'h00D, 1);
        measure(per);
        chk(per, AWAKE_DIV * HF_DIV_CYCLES);
        drive(10'h000, 3);
        chk(buzzer_n, 1'b0);
        @(posedge clk_sys);
        read_req <= 1'b1;
        measure(per);
        measure(per);
        chk(per, READ_DIV * HF_DIV_CYCLES);
        @(posedge clk_sys);
        read_req <= 1'b0;
        pin(1'b0, 5);
        chk({stat.state, stat.power_up_flag, stat.gie, stat.pll_on, ph1, ph2}, {PSCG_DEEP, 5'h00});
        done("awake");
        drive(10'h081, 1);
        drive(10'h101, 1);
        chk({stat.state, stat.power_up_flag, stat.pll_on, sleep_ctl, pok_oe_n}, {PSCG_LIGHT, 4'hD});
        drive(10'h201, 1);
        chk(stat.state, PSCG_LIGHT);
        measure(per);
        chk(per, LIGHT_DIV * XTAL_DIV_CYCLES);
        drive(10'h041, 1);
        chk(stat.state, PSCG_AWAKE);
        drive(10'h201, 1);
        chk({stat.state, stat.power_up_flag}, {PSCG_DEEP, 1'b1});
        drive(10'h041, 1);
        chk(stat.state, PSCG_AWAKE);
        cyc(30);
        pin(1'b1, 3);
        chk({stat.state, stat.power_up_flag}, {PSCG_DEEP, 1'b0});
        done("sleep");
        drive(10'h081, 1);
        drive(10'h003, 25);
        cyc(2);
        chk(stat.state, PSCG_AWAKE);
        drive(10'h003, 35);
        cyc(2);
        chk({stat.state, stat.power_up_flag}, {PSCG_DEEP, 1'b0});
        done("keys");
        exp_sf = {PSCG_DEEP, 1'b0};
        repeat (300) begin
            @(posedge clk_sys);
            exp_sf = nxt(exp_sf, ctl_b);
            ctl_b <= pscg_ctl_t'(10'($random(seed)) & 10'h3FD);
            #1;
            chk({stat.state, stat.power_up_flag}, exp_sf);
        end
        done("random");
        stop_test();
    end
endmodule
